//--- compact_branch_multi_decode.sv
`timescale 1ns/1ps
// How it works
// - Store form writes each listed low register from base, then writes base back.
// - Load form reads each listed low register from base, then writes base back.
// - Address rises one word per register; new base is base plus four times count.
// - Branch targets use the instruction address plus four.
// - Code 0000 branches on zero set, 0001 on zero clear.
// - Code 0010 branches on carry set, 0011 on carry clear.
// - Code 0100 branches on negative set, 0101 on negative clear.
// - Code 0110 branches on overflow set, 0111 on overflow clear.
// - 1000 needs carry set and zero clear; 1001 carry clear or zero set.
// - 1010 needs negative equal overflow; 1011 needs them different.
// - 1100 zero clear and N equals V; 1101 zero set or N differs V.
// - Conditional offset is a signed halfword count doubled into nine bits.
// - Condition 1111 is the software trap, not a branch.
// - Trap saves next address and status, jumps to 0x8, 32-bit supervisor.
// - The trap comment byte does not change behaviour.
// - Unconditional branch adds its doubled 11-bit field, reach -2048 to +2046.
// - Unconditional displacement is twelve bits signed with bit 0 zero.
// - Long branch carries a 22-bit halfword offset in two 11-bit halves.
// - First half: upper field shifted 12 added to PC goes into link.
// - Cycle counts match the equivalent wide-state instructions.
module compact_branch_multi_decode
  import cisa_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // Instruction from fetch.
  input  wire logic        instr_valid,
  input  wire logic [15:0] instr,
  input  wire logic [31:0] instr_addr,
  output logic             instr_ready,
  // Register file read.
  output logic [2:0]       rf_raddr,
  input  wire logic [31:0] rf_rdata,
  input  wire logic [31:0] base_rdata,
  output logic [2:0]       base_reg,
  // Register file write.
  output logic             rf_we,
  output logic [3:0]       rf_waddr,
  output logic [31:0]      rf_wdata,
  // Data memory.
  output logic             mem_req,
  output logic             mem_we,
  output logic [31:0]      mem_addr,
  output logic [31:0]      mem_wdata,
  input  wire logic [31:0] mem_rdata,
  input  wire logic        mem_ack,
  // Program counter redirect.
  output logic             pc_load,
  output logic [31:0]      pc_target,
  // Status words.
  input  wire logic [31:0] current_status_word,
  output logic [31:0]      saved_status_word,
  output logic             status_we,
  output logic [31:0]      status_wdata,
  output logic             wide_state_q_out
);

  localparam logic [3:0] LINK_INDEX = 4'hE;

  mem_port_if mp ();

  xfer_state_t st_q;
  logic        is_load_q;
  logic [2:0]  base_q;
  logic [31:0] link_reg_q;
  logic        pass;
  logic        accept;
  logic [3:0]  op;
  logic [31:0] pc_val;

  // Sign extension shared by the three branch forms.
  function automatic logic [31:0] sext(input logic [31:0] v, input int bits);
    logic [31:0] r;
    r = v;
    for (int i = 0; i < 32; i++) begin
      if (i >= bits) begin
        r[i] = v[bits - 1];
      end
    end
    return r;
  endfunction

  assign op     = instr[OP_HI:OP_LO];
  assign pc_val = instr_addr + PREFETCH_BYTES;
  // Taking only while ready is shown keeps fetch and sequencer in step after a transfer.
  assign accept = instr_valid && instr_ready && (st_q == ST_IDLE);

  branch_cond_unit u_cond (
    .cond   (instr[COND_HI:COND_LO]),
    .flag_n (current_status_word[FLAG_N]),
    .flag_z (current_status_word[FLAG_Z]),
    .flag_c (current_status_word[FLAG_C]),
    .flag_v (current_status_word[FLAG_V]),
    .pass   (pass)
  );

  multi_addr_unit u_addr (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .mp      (mp.unit)
  );

  // Sequencer control toward the address unit.
  assign mp.start = accept && (op == OP_MULTI);
  assign mp.base  = base_rdata;
  assign mp.list  = instr[LIST_HI:LIST_LO];
  assign mp.step  = (st_q == ST_XFER) && mem_ack;

  // Multiple-transfer sequence: one memory word per listed register, then base write-back.
  // An empty list goes straight to write-back, which leaves the base unchanged.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_q      <= ST_IDLE;
      is_load_q <= 1'b0;
      base_q    <= 3'h0;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (mp.start) begin
            is_load_q <= instr[LS_BIT];
            base_q    <= instr[BASE_HI:BASE_LO];
            st_q      <= (instr[LIST_HI:LIST_LO] == 8'h00) ? ST_WBACK : ST_XFER;
          end
        end
        ST_XFER: begin
          if (mem_ack && mp.last) begin
            st_q <= ST_WBACK;
          end
        end
        ST_WBACK: st_q <= ST_DONE;
        ST_DONE:  st_q <= ST_IDLE;
        default:  st_q <= ST_IDLE;
      endcase
    end
  end

  // Fetch is held while a transfer runs, so the transfer costs as many cycles as memory takes.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      instr_ready <= 1'b0;
    end else begin
      instr_ready <= (st_q == ST_IDLE) && !mp.start;
    end
  end

  assign rf_raddr = mp.reg_idx;
  assign base_reg = accept ? instr[BASE_HI:BASE_LO] : base_q;

  // Memory request: stores drive register data, loads return data to the register file.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mem_req   <= 1'b0;
      mem_we    <= 1'b0;
      mem_addr  <= 32'h0;
      mem_wdata <= 32'h0;
    end else begin
      mem_req   <= (st_q == ST_XFER) && !mem_ack && !mp.none_left;
      mem_we    <= !is_load_q;
      mem_addr  <= mp.addr;
      mem_wdata <= rf_rdata;
    end
  end

  // Register writes, program counter redirect and trap state changes.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rf_we             <= 1'b0;
      rf_waddr          <= 4'h0;
      rf_wdata          <= 32'h0;
      pc_load           <= 1'b0;
      pc_target         <= 32'h0;
      link_reg_q        <= 32'h0;
      saved_status_word <= 32'h0;
      status_we         <= 1'b0;
      status_wdata      <= STATUS_RESET;
      wide_state_q_out  <= 1'b1;
    end else begin
      rf_we     <= 1'b0;
      pc_load   <= 1'b0;
      status_we <= 1'b0;
      if ((st_q == ST_XFER) && mem_ack && is_load_q) begin
        rf_we    <= 1'b1;
        rf_waddr <= {1'b0, mp.reg_idx};
        rf_wdata <= mem_rdata;
      end else if (st_q == ST_WBACK) begin
        rf_we    <= 1'b1;
        rf_waddr <= {1'b0, base_q};
        rf_wdata <= mp.new_base;
      end else if (accept) begin
        wide_state_q_out <= 1'b0; // Accepted compact instructions other than the trap mean the narrow state.
        case (op)
          OP_COND: begin
            if (instr[COND_HI:COND_LO] == CC_TRAP) begin
              // Comment byte is deliberately not looked at.
              rf_we             <= 1'b1;
              rf_waddr          <= LINK_INDEX;
              rf_wdata          <= instr_addr + HALF_BYTES;
              saved_status_word <= current_status_word;
              status_we         <= 1'b1;
              status_wdata      <= {current_status_word[31:IRQ_MASK_BIT + 1], 1'b1,
                                    current_status_word[IRQ_MASK_BIT - 1:STATE_BIT + 1],
                                    1'b0, MODE_SUPER};
              wide_state_q_out  <= 1'b1;
              pc_load           <= 1'b1;
              pc_target         <= TRAP_VECTOR;
            end else if (pass) begin
              // Code 1110 fails in the condition unit and falls through.
              pc_load   <= 1'b1;
              pc_target <= pc_val + sext({23'h0, instr[DISP8_HI:0], 1'b0}, 9);
            end
          end
          OP_UNC: begin
            if (!instr[UNC_SEL_BIT]) begin
              pc_load   <= 1'b1;
              pc_target <= pc_val + sext({20'h0, instr[DISP11_HI:0], 1'b0}, 12);
            end
          end
          OP_LONG: begin
            if (!instr[HALF_BIT]) begin
              // Upper half of a 22-bit halfword offset.
              link_reg_q <= pc_val + sext({9'h0, instr[DISP11_HI:0], 12'h000}, 23);
              rf_we      <= 1'b1;
              rf_waddr   <= LINK_INDEX;
              rf_wdata   <= pc_val + sext({9'h0, instr[DISP11_HI:0], 12'h000}, 23);
            end else begin
              pc_load    <= 1'b1;
              pc_target  <= link_reg_q + {20'h0, instr[DISP11_HI:0], 1'b0};
              link_reg_q <= (instr_addr + HALF_BYTES) | 32'h1;
              rf_we      <= 1'b1;
              rf_waddr   <= LINK_INDEX;
              rf_wdata   <= (instr_addr + HALF_BYTES) | 32'h1;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

endmodule

//--- cisa_pkg.sv
package cisa_pkg;

  // Field positions of the compact 16-bit encodings handled here.
  localparam int OP_HI       = 15;
  localparam int OP_LO       = 12;
  localparam int LS_BIT      = 11;
  localparam int BASE_HI     = 10;
  localparam int BASE_LO     = 8;
  localparam int LIST_HI     = 7;
  localparam int LIST_LO     = 0;
  localparam int COND_HI     = 11;
  localparam int COND_LO     = 8;
  localparam int DISP8_HI    = 7;
  localparam int DISP11_HI   = 10;
  localparam int UNC_SEL_BIT = 11;
  localparam int HALF_BIT    = 11;

  // Opcode values of the top four bits.
  localparam logic [3:0] OP_MULTI = 4'hC;
  localparam logic [3:0] OP_COND  = 4'hD;
  localparam logic [3:0] OP_UNC   = 4'hE;
  localparam logic [3:0] OP_LONG  = 4'hF;

  // Condition codes.
  localparam logic [3:0] CC_EQ   = 4'h0;
  localparam logic [3:0] CC_NE   = 4'h1;
  localparam logic [3:0] CC_CS   = 4'h2;
  localparam logic [3:0] CC_CC   = 4'h3;
  localparam logic [3:0] CC_MI   = 4'h4;
  localparam logic [3:0] CC_PL   = 4'h5;
  localparam logic [3:0] CC_VS   = 4'h6;
  localparam logic [3:0] CC_VC   = 4'h7;
  localparam logic [3:0] CC_HI   = 4'h8;
  localparam logic [3:0] CC_LS   = 4'h9;
  localparam logic [3:0] CC_GE   = 4'hA;
  localparam logic [3:0] CC_LT   = 4'hB;
  localparam logic [3:0] CC_GT   = 4'hC;
  localparam logic [3:0] CC_LE   = 4'hD;
  localparam logic [3:0] CC_UNDF = 4'hE;
  localparam logic [3:0] CC_TRAP = 4'hF;

  // Addresses, offsets and mode values.
  localparam logic [31:0] PREFETCH_BYTES = 32'h0000_0004;
  localparam logic [31:0] WORD_BYTES     = 32'h0000_0004;
  localparam logic [31:0] HALF_BYTES     = 32'h0000_0002;
  localparam logic [31:0] TRAP_VECTOR    = 32'h0000_0008;
  localparam logic [4:0]  MODE_SUPER     = 5'h13;
  localparam int          STATE_BIT      = 5;
  localparam int          IRQ_MASK_BIT   = 7;
  localparam int          MODE_HI        = 4;
  localparam int          FLAG_N         = 31;
  localparam int          FLAG_Z         = 30;
  localparam int          FLAG_C         = 29;
  localparam int          FLAG_V         = 28;
  localparam logic [31:0] STATUS_RESET   = 32'h0000_00D3;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_XFER  = 3'b001,
    ST_WBACK = 3'b011,
    ST_DONE  = 3'b010
  } xfer_state_t;

endpackage

//--- mem_port_if.sv
`timescale 1ns/1ps
// Word port between the sequencer and the multiple-transfer address unit.
interface mem_port_if;
  logic        start;
  logic [31:0] base;
  logic [7:0]  list;
  logic        step;
  logic [2:0]  reg_idx;
  logic [31:0] addr;
  logic        last;
  logic        none_left;
  logic [31:0] new_base;

  modport seq (output start, output base, output list, output step,
               input reg_idx, input addr, input last, input none_left, input new_base);
  modport unit (input start, input base, input list, input step,
                output reg_idx, output addr, output last, output none_left, output new_base);
endinterface

//--- multi_addr_unit.sv
`timescale 1ns/1ps
// Walks a register list lowest first and produces one word address per step.
module multi_addr_unit
  import cisa_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_n,
  // Sequencer side.
  mem_port_if.unit mp
);

  logic [7:0]  left_q;
  logic [31:0] addr_q;
  logic [31:0] end_q;

  // Count of set bits, used for the written-back base.
  function automatic logic [31:0] ones(input logic [7:0] v);
    logic [31:0] n;
    n = 32'h0;
    for (int i = 0; i < 8; i++) begin
      n = n + {31'h0, v[i]};
    end
    return n;
  endfunction

  // Lowest set bit of the remaining list.
  function automatic logic [2:0] lowest(input logic [7:0] v);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (v[i]) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction

  // Remaining list and running address; each step moves one word up.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      left_q <= 8'h00;
      addr_q <= 32'h0;
      end_q  <= 32'h0;
    end else if (mp.start) begin
      left_q <= mp.list;
      addr_q <= mp.base;
      end_q  <= mp.base + (ones(mp.list) << 2);
    end else if (mp.step) begin
      left_q[lowest(left_q)] <= 1'b0;
      addr_q <= addr_q + WORD_BYTES;
    end
  end

  assign mp.reg_idx   = lowest(left_q);
  assign mp.addr      = addr_q;
  assign mp.none_left = (left_q == 8'h00);
  assign mp.last      = (left_q & (left_q - 8'h01)) == 8'h00;
  assign mp.new_base  = end_q;

endmodule

//--- branch_cond_unit.sv
`timescale 1ns/1ps
// Evaluates the 4-bit condition against the status flags.
module branch_cond_unit
  import cisa_pkg::*;
(
  // Inputs.
  input  wire logic [3:0] cond,
  input  wire logic       flag_n,
  input  wire logic       flag_z,
  input  wire logic       flag_c,
  input  wire logic       flag_v,
  // Result.
  output logic            pass
);

  // Undefined and trap codes never pass; the trap is decoded elsewhere.
  always_comb begin
    case (cond)
      CC_EQ:   pass = flag_z;
      CC_NE:   pass = !flag_z;
      CC_CS:   pass = flag_c;
      CC_CC:   pass = !flag_c;
      CC_MI:   pass = flag_n;
      CC_PL:   pass = !flag_n;
      CC_VS:   pass = flag_v;
      CC_VC:   pass = !flag_v;
      CC_HI:   pass = flag_c && !flag_z;
      CC_LS:   pass = !flag_c || flag_z;
      CC_GE:   pass = (flag_n == flag_v);
      CC_LT:   pass = (flag_n != flag_v);
      CC_GT:   pass = !flag_z && (flag_n == flag_v);
      CC_LE:   pass = flag_z || (flag_n != flag_v);
      default: pass = 1'b0;
    endcase
  end

endmodule

//--- cbmd_props.sv
`timescale 1ns/1ps
// Port-level checks on the decoder; it only watches and never drives.
module cbmd_props
  import cisa_pkg::*;
(
  // Clock, reset and fetch.
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic        instr_valid,
  input wire logic [15:0] instr,
  input wire logic [31:0] instr_addr,
  input wire logic        instr_ready,
  // Results.
  input wire logic        rf_we,
  input wire logic [3:0]  rf_waddr,
  input wire logic [31:0] rf_wdata,
  input wire logic        mem_req,
  input wire logic [31:0] mem_addr,
  input wire logic        mem_ack,
  input wire logic        pc_load,
  input wire logic [31:0] pc_target,
  input wire logic [31:0] current_status_word,
  input wire logic        status_we,
  input wire logic [31:0] status_wdata
);
  logic        acked_q;
  logic [31:0] ack_addr_q;
  wire         take = instr_valid && instr_ready;

  default clocking dc @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  // Remembers the last acknowledged word; cleared when idle so a new list starts fresh.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      acked_q    <= 1'b0;
      ack_addr_q <= 32'h0000_0000;
    end else if (instr_ready) begin
      acked_q <= 1'b0;
    end else if (mem_req && mem_ack) begin
      acked_q    <= 1'b1;
      ack_addr_q <= mem_addr;
    end
  end

  a_busy_refuses: assert property (mem_req |-> !instr_ready)
    else $error("fetch accepted during a multiple transfer");
  a_word_held: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
    else $error("memory request changed before acknowledge");
  a_addr_step: assert property (mem_req && acked_q
    |-> mem_addr == ack_addr_q + WORD_BYTES)
    else $error("transfer address did not advance one word");
  a_trap_vector: assert property (status_we |-> pc_load && pc_target == TRAP_VECTOR)
    else $error("trap did not redirect to its vector");
  a_trap_mode: assert property (status_we |-> status_wdata[MODE_HI:0] == MODE_SUPER)
    else $error("trap did not select supervisor mode");
  a_target_even: assert property (pc_load && !status_we |-> !pc_target[0])
    else $error("branch target not halfword aligned");
  a_undef_idle: assert property (take && instr[15:12] == OP_UNC && instr[UNC_SEL_BIT]
    |=> !pc_load && !status_we)
    else $error("reserved encoding caused an action");
  a_eq_target: assert property (take && instr[15:8] == 8'hD0 && current_status_word[FLAG_Z]
    |=> pc_load && pc_target == $past(instr_addr) + PREFETCH_BYTES
      + {{23{$past(instr[7])}}, $past(instr[7:0]), 1'b0})
    else $error("equal branch target wrong");
  a_eq_skip: assert property (take && instr[15:8] == 8'hD0 && !current_status_word[FLAG_Z]
    |=> !pc_load)
    else $error("equal branch taken with zero clear");
  a_unc_target: assert property (take && instr[15:11] == 5'b11100
    |=> pc_load && pc_target == $past(instr_addr) + PREFETCH_BYTES
      + {{20{$past(instr[10])}}, $past(instr[10:0]), 1'b0})
    else $error("unconditional branch target wrong");
  a_link_odd: assert property (rf_we && rf_waddr == 4'hE && pc_load && !status_we
    |-> rf_wdata[0])
    else $error("long branch link lacks bit 0");
endmodule

bind compact_branch_multi_decode cbmd_props i_cbmd_props (.*);

//--- test_compact_branch_multi_decode.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
  total_checks++; \
  if ((g) !== (e)) begin \
    mismatches++; \
    $display("[ERR] %s expected %h seen %h", nm, e, g); \
  end \
end
// Acts as fetch, register file and memory around the decoder and scores every result.
module test_compact_branch_multi_decode
  import cisa_pkg::*;
;
  logic        clk_sys, rst_n, instr_valid, instr_ready, rf_we, mem_req, mem_we, mem_ack;
  logic        pc_load, status_we, wide_state_q_out;
  logic [15:0] instr;
  logic [2:0]  rf_raddr, base_reg;
  logic [3:0]  rf_waddr;
  logic [31:0] instr_addr, rf_rdata, base_rdata, rf_wdata, mem_addr, mem_wdata, mem_rdata;
  logic [31:0] pc_target, current_status_word, saved_status_word, status_wdata, base_val;
  logic [31:0] regs [8];
  logic [31:0] rdq[$];
  logic [67:0] notes[$];
  int          mismatches, total_checks;

  compact_branch_multi_decode i_compact_branch_multi_decode (.*);

  // The register file answers in the same cycle.
  assign rf_rdata   = regs[rf_raddr];
  assign base_rdata = base_val;

  // Clock of 40 ns.
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  function automatic logic taken(input logic [3:0] c, input logic [3:0] f);
    logic n, z, cy, v;
    {n, z, cy, v} = f;
    case (c)
      CC_EQ: return z;
      CC_NE: return !z;
      CC_CS: return cy;
      CC_CC: return !cy;
      CC_MI: return n;
      CC_PL: return !n;
      CC_VS: return v;
      CC_VC: return !v;
      CC_HI: return cy && !z;
      CC_LS: return !cy || z;
      CC_GE: return n == v;
      CC_LT: return n != v;
      CC_GT: return !z && n == v;
      CC_LE: return z || n != v;
      default: return 1'b0;
    endcase
  endfunction

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Presents one instruction at the falling edge and holds it until it is taken.
  task automatic issue(input logic [15:0] op, input logic [31:0] at, input logic [31:0] sw);
    int n;
    @(negedge clk_sys);
    instr_valid         = 1'b1;
    instr               = op;
    instr_addr          = at;
    current_status_word = sw;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (instr_ready !== 1'b1 && n < 300);
    `CHK("instruction taken", 1'b1, instr_ready)
  endtask

  // Withdraws the instruction and lets n cycles pass.
  task automatic idle(input int n);
    @(negedge clk_sys);
    instr_valid = 1'b0;
    instr       = ~instr;
    repeat (n) @(negedge clk_sys);
  endtask

  // One multiple transfer; base never sits in a load list so write-back stays unambiguous.
  task automatic multi(input logic ld, input logic [7:0] lst);
    logic [2:0]  b;
    logic [31:0] ad;
    logic [31:0] d;
    int          n;
    b = 3'($urandom);
    base_val = $urandom & 32'hFFFF_FFFC;
    foreach (regs[i]) regs[i] = $urandom;
    regs[b] = base_val;
    if (ld) lst = lst & ~(8'h01 << b);
    if (lst == 8'h00) lst = 8'h01 << (b + 3'd1);
    ad = base_val;
    for (int i = 0; i < 8; i++) begin
      if (lst[i]) begin
        d = $urandom;
        if (ld) begin
          notes.push_back({4'h3, ad, 32'h0});
          notes.push_back({4'h1, 32'(i), d});
          rdq.push_back(d);
        end else begin
          notes.push_back({4'h2, ad, regs[i]});
        end
        ad += WORD_BYTES;
      end
    end
    notes.push_back({4'h1, 29'h0, b, ad});
    issue({OP_MULTI, ld, b, lst}, $urandom & 32'hFFFF_FFFE, $urandom);
    idle(1);
    n = 0;
    while (instr_ready !== 1'b1 && n < 300) begin
      @(negedge clk_sys);
      n++;
    end
  endtask

  // Memory acknowledges each word after a random stall; read data is scrambled otherwise.
  initial begin
    forever begin
      @(negedge clk_sys);
      if (mem_req === 1'b1 && mem_ack === 1'b0) begin
        repeat ($urandom % 3) @(negedge clk_sys);
        mem_ack = 1'b1;
        if (!mem_we && rdq.size() > 0) mem_rdata = rdq.pop_front();
        @(negedge clk_sys);
        mem_ack   = 1'b0;
        mem_rdata = ~mem_rdata;
      end
    end
  end

  // Takes the oldest note for every result the decoder shows.
  task automatic seen(input logic [67:0] got);
    logic [67:0] e;
    e = '1;
    if (notes.size() > 0) e = notes.pop_front();
    `CHK("decoder result", e, got)
  endtask

  // Results are read before the edge's own updates land, so they are the settled ones.
  always @(posedge clk_sys) begin
    if (rst_n) begin
      if (pc_load) seen({4'h0, pc_target, 32'h0});
      if (rf_we) seen({4'h1, 28'h0, rf_waddr, rf_wdata});
      if (mem_req && mem_ack) seen({mem_we ? 4'h2 : 4'h3, mem_addr, mem_we ? mem_wdata : 32'h0});
      if (status_we) seen({4'h4, status_wdata, 32'h0});
    end
  end

  // Watchdog sized well past the expected few hundred cycles.
  initial begin
    repeat (20000) @(posedge clk_sys);
    mismatches++;
    give_verdict();
  end

  initial begin
    logic [31:0] a, sw, lnk;
    logic [15:0] op;
    logic [10:0] hi, lo;
    logic [10:0] offs [5];
    void'($urandom(32'h65CB));
    rst_n = 1'b0;
    instr_valid = 1'b0;
    instr = 16'h0000;
    instr_addr = 32'h0000_0000;
    mem_ack = 1'b0;
    mem_rdata = 32'h0000_0000;
    current_status_word = 32'h0000_0000;
    base_val = 32'h0000_0000;
    foreach (regs[i]) regs[i] = 32'h0000_0000;
    repeat (12) @(negedge clk_sys);
    rst_n = 1'b1;
    `CHK("wide state after reset", 1'b1, wide_state_q_out)
    // Every condition code but 1110, back to back, with random flags and offsets.
    // Condition 1110 is never generated, as a code generator must not use it.
    for (int c = 0; c < 16; c++) begin
      if (c == 14) continue;
      repeat (4) begin
        a = $urandom & 32'h00FF_FFFE;
        sw = $urandom;
        op = {OP_COND, 4'(c), 8'($urandom)};
        if (c == 15) begin
          notes.push_back({4'h0, TRAP_VECTOR, 32'h0});
          notes.push_back({4'h1, 32'hE, a + HALF_BYTES});
          notes.push_back({4'h4, sw[31:8], 1'b1, sw[6], 1'b0, MODE_SUPER, 32'h0});
        end else if (c != 14 && taken(4'(c), sw[31:28])) begin
          notes.push_back({4'h0, a + PREFETCH_BYTES + {{23{op[7]}}, op[7:0], 1'b0}, 32'h0});
        end
        issue(op, a, sw);
        if (c == 15) begin
          idle(2);
          `CHK("saved status", sw, saved_status_word)
          `CHK("wide state", 1'b1, wide_state_q_out)
        end
      end
    end
    // Unconditional branches at the ends of their reach, then the unused neighbour encoding.
    offs = '{11'h3FF, 11'h400, 11'h000, 11'h7FF, 11'($urandom)};
    foreach (offs[i]) begin
      a = $urandom & 32'h00FF_FFFE;
      notes.push_back({4'h0, a + PREFETCH_BYTES + {{20{offs[i][10]}}, offs[i], 1'b0}, 32'h0});
      issue({5'b11100, offs[i]}, a, $urandom);
      issue({5'b11101, offs[i]}, a, $urandom);
    end
    // Long branch pairs, the first with the most negative upper half, the rest random.
    for (int k = 0; k < 4; k++) begin
      a = $urandom & 32'h00FF_FFFE;
      hi = (k == 0) ? 11'h400 : 11'($urandom);
      lo = 11'($urandom);
      lnk = a + PREFETCH_BYTES + {{9{hi[10]}}, hi, 12'h000};
      notes.push_back({4'h1, 32'hE, lnk});
      // The lower half carries no sign of its own, so it is added unsigned.
      notes.push_back({4'h0, lnk + {20'h0, lo, 1'b0}, 32'h0});
      notes.push_back({4'h1, 32'hE, (a + 32'h4) | 32'h1});
      issue({OP_LONG, 1'b0, hi}, a, $urandom);
      issue({OP_LONG, 1'b1, lo}, a + HALF_BYTES, $urandom);
    end
    idle(2);
    `CHK("narrow state after branches", 1'b0, wide_state_q_out)
    // Stores and loads with full, single and random lists under memory stalls.
    multi(1'b0, 8'hFF);
    multi(1'b1, 8'hFF);
    multi(1'b0, 8'h80);
    multi(1'b1, 8'h01);
    repeat (4) multi(1'($urandom), 8'($urandom));
    idle(6);
    `CHK("pending results", 0, notes.size())
    give_verdict();
  end
endmodule
